/* hdl/eer_pkg.sv */
// constants, types and rule summary for the i2c eeprom read path
// Operation
// R1: in standby the counter names the byte after the last one accessed
// R2: after the highest location the held counter returns to location zero
// R3: own address with read bit gets ack in ninth clock, then data msb first
// R4: master ends a read with not-acknowledge then stop
// R5: dummy write loads the counter so a read may start anywhere
// R6: selective read: start, address with write bit, one address byte, no data
// R7: after address byte ack master sends repeated start and read address
// R8: each master-acknowledged byte advances the counter and sends the next
// R9: continuous read wraps past the top to zero without interruption
// R10: sequential reading follows both immediate and selective starts
// R11: array of 256 bytes, eight-bit counter wrapping modulo 256
// R12: answer only to preamble 1010 with matching three select bits
// R13: no address ack while an internal write cycle runs
// R14: on master not-acknowledge stop sending, release data, wait for stop
// R15: data line released in the ninth clock of every transmitted byte
// R16: counter advances after each byte moved in either direction; here only read bytes advance it, written data bytes leave it unchanged
package eer_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam logic [3:0]  PREAMBLE   = 4'h000a;
  localparam logic [2:0]  BIT_LAST   = 3'h0007;
  localparam logic        DIR_READ   = 1'b1;

  typedef enum logic [2:0] {
    EER_IDLE  = 3'b000,
    EER_DEVA  = 3'b001,
    EER_DEVAK = 3'b011,
    EER_WADDR = 3'b010,
    EER_WACK  = 3'b110,
    EER_RDAT  = 3'b111,
    EER_RACK  = 3'b101,
    EER_WAIT  = 3'b100
  } eer_state_e;

  // memory read request crossing from link domain to array domain
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } eer_req_s;

  // byte access report from array domain
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eer_word_s;
endpackage : eer_pkg

/* hdl/eer_fifo.sv */
// parameterised valid/ready fifo, gray pointers across two clocks
`timescale 1ns/1ps
`default_nettype none
module eer_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // write side
  input  wire logic             wclk,
  input  wire logic             wrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // read side
  input  wire logic             rclk,
  input  wire logic             rrst,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two, at least four");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin, rbin, wgray, rgray;
  logic [AW:0]      rg_s1, rg_s2, wg_s1, wg_s2;
  wire  [AW:0]      wbin_n  = wbin + (AW+1)'(1);
  wire  [AW:0]      rbin_n  = rbin + (AW+1)'(1);
  wire              push    = in_valid & in_ready;
  wire              pop     = out_valid & out_ready;

  // full when write gray equals read gray with top two bits inverted
  assign in_ready  = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign out_valid = (rgray != wg_s2);
  assign out_data  = mem[rbin[AW-1:0]];

  always_ff @(posedge wclk) begin
    if (push) mem[wbin[AW-1:0]] <= in_data;
  end
  always_ff @(posedge wclk) begin
    if (wrst) begin
      wbin  <= '0;
      wgray <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      rg_s1 <= rgray;
      rg_s2 <= rg_s1;
      if (push) begin
        wbin  <= wbin_n;
        wgray <= wbin_n ^ (wbin_n >> 1);
      end
    end
  end
  always_ff @(posedge rclk) begin
    if (rrst) begin
      rbin  <= '0;
      rgray <= '0;
      wg_s1 <= '0;
      wg_s2 <= '0;
    end else begin
      wg_s1 <= wgray;
      wg_s2 <= wg_s1;
      if (pop) begin
        rbin  <= rbin_n;
        rgray <= rbin_n ^ (rbin_n >> 1);
      end
    end
  end
endmodule : eer_fifo
`default_nettype wire

/* hdl/eer_read_path.sv */
// i2c eeprom slave: address counter, read sequencing, array
`timescale 1ns/1ps
`default_nettype none
module eer_read_path #(
  parameter int unsigned ADDR_W = eer_pkg::ADDR_W,
  parameter int unsigned DEPTH  = eer_pkg::FIFO_DEPTH
) (
  // system clock and reset
  input  wire logic              mclk,
  input  wire logic              srst,
  // i2c link, scl is the link clock
  input  wire logic              scl,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // strapped select inputs and write status
  input  wire logic [2:0]        dev_sel,
  input  wire logic              write_busy,
  // array preload port, system domain
  input  wire logic              load_en,
  input  wire logic [ADDR_W-1:0] load_addr,
  input  wire logic [7:0]        load_data,
  // status, system domain
  output logic [ADDR_W-1:0]      held_addr,
  output logic                   read_active
);
  initial begin
    if (ADDR_W != eer_pkg::ADDR_W) $error("address width fixed by array size");
  end
  localparam int unsigned WW = $bits(eer_pkg::eer_word_s);

  // ---------------- system domain: array and counter ----------------
  logic [7:0]        mem [1 << ADDR_W];
  logic [ADDR_W-1:0] ctr;
  wire  [ADDR_W-1:0] ctr_next = ctr + ADDR_W'(1);
  logic [2:0]        sel_s1, sel_s2;
  logic              busy_s1, busy_s2;
  logic [7:0]        rd_byte;

  // link-domain control crossings (toggles)
  logic              l_load_tgl, l_adv_tgl;
  logic [ADDR_W-1:0] l_load_val;
  logic [2:0]        ld_sync, adv_sync;
  wire               m_load = ld_sync[2] ^ ld_sync[1];
  wire               m_adv  = adv_sync[2] ^ adv_sync[1];
  logic [ADDR_W-1:0] l_val_s1, l_val_s2;

  always_ff @(posedge mclk) begin
    if (load_en) mem[load_addr] <= load_data;
  end

  // held pointer names byte after the last accessed, wraps mod 256
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctr <= '0;
    end else if (m_load) begin
      ctr <= l_val_s2;                                  // see R5
    end else if (m_adv) begin
      ctr <= ctr_next;                                  // see R1 see R2 see R11 see R16
    end
  end
  assign held_addr = ctr;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ld_sync  <= '0;
      adv_sync <= '0;
      l_val_s1 <= '0;
      l_val_s2 <= '0;
      sel_s1   <= '0;
      sel_s2   <= '0;
      busy_s1  <= 1'b0;
      busy_s2  <= 1'b0;
    end else begin
      ld_sync  <= {ld_sync[1:0], l_load_tgl};
      adv_sync <= {adv_sync[1:0], l_adv_tgl};
      l_val_s1 <= l_load_val;
      l_val_s2 <= l_val_s1;
      sel_s1   <= dev_sel;
      sel_s2   <= sel_s1;
      busy_s1  <= write_busy;
      busy_s2  <= busy_s1;
    end
  end

  // prefetch: stream bytes from counter onward into the fifo
  logic [ADDR_W-1:0] pf_addr;
  logic              pf_valid, pf_ready;
  logic              flush_s1, flush_s2, flush_q;
  logic              l_flush_tgl;
  wire               m_flush = flush_s2 ^ flush_q;
  assign rd_byte = mem[pf_addr];
  always_ff @(posedge mclk) begin
    if (srst) begin
      flush_s1 <= 1'b0;
      flush_s2 <= 1'b0;
      flush_q  <= 1'b0;
      pf_addr  <= '0;
      pf_valid <= 1'b0;
    end else begin
      flush_s1 <= l_flush_tgl;
      flush_s2 <= flush_s1;
      flush_q  <= flush_s2;
      if (m_flush | m_load) begin
        pf_valid <= 1'b0;
        // advance of the last byte lands in the same cycle as the flush
        pf_addr  <= m_load ? l_val_s2 : (m_adv ? ctr_next : ctr);
      end else begin
        pf_valid <= 1'b1;
        if (pf_valid & pf_ready) pf_addr <= pf_addr + ADDR_W'(1);   // see R9
      end
    end
  end

  // ---------------- link domain: scl clocked ----------------
  logic l_rst_s1, l_rst;
  always_ff @(posedge scl) begin
    l_rst_s1 <= srst;
    l_rst    <= l_rst_s1;
  end

  eer_pkg::eer_word_s f_in, f_out;
  logic               f_valid, f_pop;
  logic               l_fifo_clr;
  assign f_in = '{addr: pf_addr, data: rd_byte};

  eer_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
    .wclk      (mclk),
    .wrst      (srst | m_flush | m_load),
    .in_valid  (pf_valid),
    .in_ready  (pf_ready),
    .in_data   (f_in),
    .rclk      (scl),
    .rrst      (l_rst | l_fifo_clr),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_out)
  );

  // start/stop detection: sda edges while scl high
  // detectors hold their level, so only their first sighting counts
  logic start_det, stop_det, start_seen, stop_seen;
  always_ff @(negedge sda_in or posedge l_rst) begin
    if (l_rst) start_det <= 1'b0;
    else       start_det <= scl;
  end
  always_ff @(posedge sda_in or posedge l_rst) begin
    if (l_rst) stop_det <= 1'b0;
    else       stop_det <= scl;
  end

  eer_pkg::eer_state_e st;
  logic [2:0]          bitn;
  logic [7:0]          shreg, txreg;
  logic                rw_bit;
  wire                 addr_hit = (shreg[6:3] == eer_pkg::PREAMBLE) &&
                                  (shreg[2:0] == sel_s2) && !busy_s2;  // see R12 see R13

  // bits sampled on scl rise, driven on scl fall
  always_ff @(posedge scl) begin
    if (l_rst) begin
      st          <= eer_pkg::EER_IDLE;
      bitn        <= '0;
      shreg       <= '0;
      start_seen  <= 1'b0;
      stop_seen   <= 1'b0;
      l_load_tgl  <= 1'b0;
      l_adv_tgl   <= 1'b0;
      l_flush_tgl <= 1'b0;
      l_load_val  <= '0;
      rw_bit      <= 1'b0;
      l_fifo_clr  <= 1'b0;
    end else begin
      l_fifo_clr <= 1'b0;
      start_seen <= start_det;
      stop_seen  <= stop_det;
      shreg      <= {shreg[6:0], sda_in};
      bitn       <= bitn + 3'(1);
      if (start_det & !start_seen) begin
        st   <= eer_pkg::EER_DEVA;                 // repeated start also lands here, see R7
        bitn <= 3'(1);
        shreg <= {7'(0), sda_in};
      end else begin
        case (st)
          eer_pkg::EER_DEVA: if (bitn == eer_pkg::BIT_LAST) begin
            rw_bit <= sda_in;
            st     <= addr_hit ? eer_pkg::EER_DEVAK : eer_pkg::EER_WAIT;
          end
          eer_pkg::EER_DEVAK: begin
            bitn <= '0;
            st   <= (rw_bit == eer_pkg::DIR_READ) ? eer_pkg::EER_RDAT : eer_pkg::EER_WADDR;
            if (rw_bit == eer_pkg::DIR_READ) l_fifo_clr <= 1'b0;
          end
          eer_pkg::EER_WADDR: if (bitn == eer_pkg::BIT_LAST) begin
            l_load_val <= {shreg[6:0], sda_in};
            st         <= eer_pkg::EER_WACK;
          end
          eer_pkg::EER_WACK: begin
            l_load_tgl <= ~l_load_tgl;             // see R5 see R6
            l_fifo_clr <= 1'b1;
            bitn       <= '0;
            st         <= eer_pkg::EER_WAIT;       // data bytes belong to the write path
          end
          eer_pkg::EER_RDAT: if (bitn == eer_pkg::BIT_LAST) st <= eer_pkg::EER_RACK;
          eer_pkg::EER_RACK: begin
            l_adv_tgl <= ~l_adv_tgl;               // see R16
            bitn      <= '0;
            if (sda_in) begin
              st          <= eer_pkg::EER_WAIT;    // see R4 see R14
              l_flush_tgl <= ~l_flush_tgl;
              l_fifo_clr  <= 1'b1;                 // write side flushes via the mclk toggle, read side resets on the next scl rise
            end else begin
              st <= eer_pkg::EER_RDAT;             // see R8 see R10
            end
          end
          eer_pkg::EER_IDLE,
          eer_pkg::EER_WAIT: bitn <= '0;
          default:           st   <= eer_pkg::EER_IDLE;
        endcase
      end
      if (stop_det & !stop_seen) st <= eer_pkg::EER_IDLE;
    end
  end

  // drive side: updates on scl fall so sda is stable while scl high
  logic drive_low;
  wire  load_tx = (st == eer_pkg::EER_DEVAK && rw_bit) || (st == eer_pkg::EER_RACK && !sda_in);
  assign f_pop = (st == eer_pkg::EER_RDAT) && (bitn == '0) && f_valid;
  always_ff @(negedge scl) begin
    if (l_rst) begin
      drive_low <= 1'b0;
      txreg     <= '0;
    end else begin
      case (st)
        eer_pkg::EER_DEVAK,
        eer_pkg::EER_WACK: drive_low <= 1'b1;                   // see R3
        eer_pkg::EER_RDAT: begin
          drive_low <= ~(bitn == '0 ? f_out.data[7] : txreg[7]); // see R3
          txreg     <= bitn == '0 ? {f_out.data[6:0], 1'b0} : {txreg[6:0], 1'b0};
        end
        default:           drive_low <= 1'b0;                   // see R15 see R14
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe  = drive_low;

  logic act_s1, act_s2;
  always_ff @(posedge mclk) begin
    if (srst) begin
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      act_s1 <= (st == eer_pkg::EER_RDAT) || (st == eer_pkg::EER_RACK);
      act_s2 <= act_s1;
    end
  end
  assign read_active = act_s2;
  wire unused_ok = ^{load_tx, f_out.addr};
endmodule : eer_read_path
`default_nettype wire

/* verif/eer_read_path_assertions.sv */
// port-level checks of the i2c read path
`timescale 1ns/1ps
`default_nettype none
module eer_read_path_assertions #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DEPTH  = 8
) (
  // watched ports
  input wire logic              mclk,
  input wire logic              srst,
  input wire logic              scl,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic [2:0]        dev_sel,
  input wire logic              write_busy,
  input wire logic              load_en,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [7:0]        load_data,
  input wire logic [ADDR_W-1:0] held_addr,
  input wire logic              read_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // bus idle time in mclk cycles, saturating
  logic [5:0] idle_cnt;
  always_ff @(posedge mclk) begin
    if (srst || !(scl && sda_in)) idle_cnt <= 6'h00;
    else if (idle_cnt != 6'h3f) idle_cnt <= idle_cnt + 6'h01;
  end
  sequence s_step;
    read_active ##1 (read_active && held_addr != $past(held_addr));
  endsequence
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_RESET_COUNTER: assert property (disable iff (1'b0) srst |=> held_addr == '0)
    else $error("counter not cleared");
  AST_RESET_IDLE: assert property (disable iff (1'b0) srst ##1 srst |=> !read_active)
    else $error("read phase during reset");
  AST_READ_STEP: assert property (s_step |-> held_addr == $past(held_addr) + 1'b1)
    else $error("counter moved by other than one");
  AST_STEP_SPACED: assert property (s_step |=> $stable(held_addr))
    else $error("counter moved twice in a row");
  AST_IDLE_HOLD: assert property (idle_cnt >= 6'h20 |-> $stable(held_addr))
    else $error("counter moved in standby");
  AST_IDLE_INACTIVE: assert property (idle_cnt == 6'h10 |-> !read_active)
    else $error("read phase outlives stop");
  AST_BUSY_NO_READ: assert property (write_busy && $past(write_busy, 4) |-> !$rose(read_active))
    else $error("read started while busy");
  COV_STEP: cover property (s_step);
endmodule : eer_read_path_assertions
bind eer_read_path eer_read_path_assertions #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) u_chk (
  .mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .dev_sel(dev_sel), .write_busy(write_busy), .load_en(load_en), .load_addr(load_addr),
  .load_data(load_data), .held_addr(held_addr), .read_active(read_active));
`default_nettype wire

/* verif/eer_i2c_master.sv */
// i2c bus master model, scl period 15 ns
`timescale 1ns/1ps
`default_nettype none
module eer_i2c_master (
  // bus
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda,
  // high in the ninth clock of a byte read from the slave
  output logic      ack_slot
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    ack_slot = 1'b0;
  end
  // scl stands still outside frames, but slave reset needs a few edges
  task automatic pulses(input int n);
    repeat (n) begin
      #7.5 scl = 1'b0;
      #7.5 scl = 1'b1;
    end
  endtask : pulses
  // data moves 1 ns after scl fall so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    #1 sda_rel = b;
    #6.5 scl = 1'b1;
    r = sda;
    #7.5 scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #1 sda_rel = 1'b1;
    #6.5 scl = 1'b1;
    #7.5 sda_rel = 1'b0;
    #7.5 scl = 1'b0;
  endtask : start
  task automatic stop();
    #1 sda_rel = 1'b0;
    #6.5 scl = 1'b1;
    #7.5 sda_rel = 1'b1;
    #7.5;
  endtask : stop
  task automatic wr8(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr8
  // a low ack continues the read, a released one ends it
  task automatic rd8(output logic [7:0] v, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    ack_slot = 1'b1;
    bit_io(~ack, r);
    ack_slot = 1'b0;
  endtask : rd8
endmodule : eer_i2c_master
`default_nettype wire

/* verif/eer_read_path_bench.sv */
// self-checking bench for the i2c read path
`timescale 1ns/1ps
`default_nettype none
module eer_read_path_bench;
  logic       mclk, srst, busy, ld, so, oe, act, scl, m_rel, slot, ack;
  logic [7:0] la, ld_d, held, rd, ptr;
  logic [2:0] sel;
  wire logic  sda = m_rel & ~(oe & ~so);
  int         error_cnt = 0;
  int         num_checks = 0;
  eer_read_path uut (.mclk(mclk), .srst(srst), .scl(scl), .sda_in(sda), .sda_out(so), .sda_oe(oe),
    .dev_sel(sel), .write_busy(busy), .load_en(ld), .load_addr(la), .load_data(ld_d),
    .held_addr(held), .read_active(act));
  eer_i2c_master m (.scl(scl), .sda_rel(m_rel), .sda(sda), .ack_slot(slot));
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction : pat
  task automatic chk(input logic c, input string s);
    num_checks++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, s);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  always @(posedge scl) if (slot) chk(oe === 1'b0, "line not released in ack slot");
  task automatic addr(input logic rw, input logic exp);
    m.start();
    m.wr8({eer_pkg::PREAMBLE, sel, rw}, ack);
    chk(ack === exp, "address ack");
  endtask : addr
  task automatic rd_n(input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      m.rd8(rd, i < n - 1);
      chk(rd === pat(ptr), "read byte");
      ptr = ptr + 8'h01;
    end
    m.bit_io(1'b1, b);
    chk(b === 1'b1, "slave drives after nack");
    m.stop();
    repeat (20) @(negedge mclk);
    chk(held === ptr, "held counter");
  endtask : rd_n
  task automatic t_load();
    for (int i = 0; i < 256; i++) begin
      @(negedge mclk);
      ld = 1'b1;
      la = i[7:0];
      ld_d = pat(i[7:0]);
    end
    @(negedge mclk);
    ld = 1'b0;
  endtask : t_load
  task automatic t_sel(input logic [7:0] a, input int n);
    addr(1'b0, 1'b1);
    m.wr8(a, ack);
    chk(ack === 1'b1, "byte address ack");
    // scl held low so the prefetch reloads
    repeat (10) @(negedge mclk);
    ptr = a;
    addr(eer_pkg::DIR_READ, 1'b1);
    rd_n(n);
  endtask : t_sel
  task automatic t_imm(input int n);
    addr(eer_pkg::DIR_READ, 1'b1);
    rd_n(n);
  endtask : t_imm
  // wrong preamble, wrong select, then right address while busy
  task automatic t_refuse();
    for (int k = 0; k < 3; k++) begin
      @(negedge mclk);
      busy = (k == 2);
      repeat (8) @(negedge mclk);
      m.start();
      m.wr8({k == 0 ? ~eer_pkg::PREAMBLE : eer_pkg::PREAMBLE, k == 1 ? ~sel : sel, 1'b1}, ack);
      chk(ack === 1'b0, "refused address acked");
      m.stop();
    end
    @(negedge mclk);
    busy = 1'b0;
    repeat (8) @(negedge mclk);
    chk(held === ptr, "counter moved by refused access");
  endtask : t_refuse
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // whole run is about 21 us
  initial begin
    #100us;
    error_cnt++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    busy = 1'b0;
    ld = 1'b0;
    la = 8'h00;
    ld_d = 8'h00;
    sel = 3'h5;
    ptr = 8'h00;
    fork
      m.pulses(8);
      repeat (16) @(negedge mclk);
    join
    srst = 1'b0;
    // link side leaves reset only on scl edges
    m.pulses(4);
    repeat (4) @(negedge mclk);
    chk(held === 8'h00 && act === 1'b0, "reset state");
    t_load();
    t_sel(8'hfd, 5);
    t_imm(2);
    t_sel(8'hff, 1);
    t_imm(3);
    t_refuse();
    t_imm(1);
    conclude();
  end
endmodule : eer_read_path_bench
`default_nettype wire
